/* File: uwc_pkg.sv */
/*
 * constants for the serial interface wire and clock control block
 * assumes a 32-bit AHB-Lite register bus with word-aligned registers
 */
`default_nettype none
package uwc_pkg;
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  CTRL_ADDR   = 8'h00;
    localparam logic [7:0]  STAT_ADDR   = 8'h04;
    localparam logic [7:0]  DATA_ADDR   = 8'h08;
    localparam logic [7:0]  PORT_ADDR   = 8'h0c;
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [2:0]  PIN_RESET   = 3'h0;
    localparam logic [3:0]  CNT_RESET   = 4'h0;
    // control register fields
    localparam int          CTRL_OVFIE  = 6;
    localparam int          CTRL_WM_HI  = 5;
    localparam int          CTRL_WM_LO  = 4;
    localparam int          CTRL_CS_HI  = 3;
    localparam int          CTRL_CS_LO  = 2;
    localparam int          CTRL_CLK    = 1;
    localparam int          CTRL_TC     = 0;
    // status register fields
    localparam int          STAT_START  = 7;
    localparam int          STAT_OVF    = 6;
    localparam int          CNT_HI      = 3;
    localparam logic [3:0]  CNT_MAX     = 4'hf;
    localparam logic [3:0]  CNT_STEP    = 4'h1;
    // pin/direction register: port bits low, direction bits from DIR_LO
    localparam int          PIN_SDA     = 0;
    localparam int          PIN_DO      = 1;
    localparam int          PIN_CK      = 2;
    localparam int          DIR_LO      = 4;
    localparam int          DIR_HI      = 6;
    localparam logic [1:0]  CS_STROBE   = 2'h0;
    localparam logic [1:0]  CS_TIMER    = 2'h1;

    typedef enum logic [1:0] {
        WM_OFF      = 2'h0,
        WM_THREE    = 2'h1,
        WM_TWO      = 2'h2,
        WM_TWO_HOLD = 2'h3
    } uwc_wire_mode_e;
endpackage : uwc_pkg
`default_nettype wire

/* File: uwc_pin_if.sv */
/*
 * synchronised serial pin levels and clock-pin edges
 * assumes producer and consumer share ref_clk
 */
`timescale 1ns/100ps
`default_nettype none
interface uwc_pin_if;
    logic dataSync;
    logic clkRise;
    logic clkFall;
    modport src (output dataSync, output clkRise, output clkFall);
    modport snk (input dataSync, input clkRise, input clkFall);
endinterface : uwc_pin_if
`default_nettype wire

/* File: uwc_pin_sync.sv */
/*
 * two-flop synchronisers for the data-in and clock pins, clock edge detect
 * assumes pins are asynchronous to ref_clk and slower than half its rate
 */
`timescale 1ns/100ps
`default_nettype none
module uwc_pin_sync (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic dataPin,
    input  wire logic clockPin,
    uwc_pin_if.src    pins
);
    logic [1:0] dataMeta_q;
    logic [1:0] clkMeta_q;
    logic       clkPrev_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dataMeta_q <= 2'h0;
            clkMeta_q  <= 2'h0;
            clkPrev_q  <= 1'b0;
        end else begin
            dataMeta_q <= {dataMeta_q[0], dataPin};
            clkMeta_q  <= {clkMeta_q[0], clockPin};
            clkPrev_q  <= clkMeta_q[1];
        end
    end

    assign pins.dataSync = dataMeta_q[1];
    assign pins.clkRise  = clkMeta_q[1] & ~clkPrev_q;
    assign pins.clkFall  = ~clkMeta_q[1] & clkPrev_q;
endmodule : uwc_pin_sync
`default_nettype wire

/* File: uwc_wire_ctrl.sv */
/*
 * wire mode and clock source control of the universal serial unit,
 * with shift data register, 4-bit counter, flags and pin drivers
 * assumes AHB-Lite master on ref_clk; timerMatch and startDetected are
 * single-cycle pulses on ref_clk; pins are asynchronous
 */
// Our own choices: the AHB-Lite slave port and the placing of the registers.
// Notes on behaviour
// R1: overflow enable bit six enables overflow interrupt
// R2: pending overflow fires once both enables set
// R3: wire mode changes outputs only, inputs always work
// R4: mode off: pins act as plain port pins
// R5: three-wire: shift MSB replaces data-out port bit
// R6: clock pin stays port; toggle strobe flips it
// R7: two-wire: open-drain lines enabled by direction bits
// R8: data line low if MSB or port zero
// R9: clock line low if port zero or start
// R10: start condition holds clock until flag cleared
// R11: two-wire disables data and clock pull-ups, inputs unchanged
// R12: mode three also holds clock on overflow
// R13: external clock latch changes on opposite edge
// R14: select zero: clock strobe clocks register, counter
// R15: timer or external edges clock per select
// R16: external plus strobe bit: toggle clocks counter
// R17: strobe shifts in input from previous cycle
// R18: clock strobe bit reads back zero
// R19: data output comes from latched shift MSB
// R20: overflow flag on wrap, cleared writing one
`timescale 1ns/100ps
`default_nettype none
module uwc_wire_ctrl (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        timerMatch,
    input  wire logic        startDetected,
    input  wire logic        globalIrqEn,
    output logic             ovfIrq,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    output logic             sdaPullup,
    output logic             doOut,
    output logic             doOe,
    output logic             doPullup,
    input  wire logic        sclIn,
    output logic             sclOut,
    output logic             sclOe,
    output logic             sclPullup
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    uwc_pin_if pins ();

    uwc_pin_sync u_sync (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .dataPin  (sdaIn),
        .clockPin (sclIn),
        .pins     (pins.src)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus slave
    logic                     accept;
    logic                     wrPend_q;
    logic                     rdPend_q;
    logic [uwc_pkg::ADDR_W-1:0] addr_q;
    logic                     wrCtrl;
    logic                     wrStat;
    logic                     wrData;
    logic                     wrPort;
    logic [31:0]              rdMux;

    logic                     ovfIe_q;
    uwc_pkg::uwc_wire_mode_e  wm_q;
    logic [1:0]               cs_q;
    logic                     clkSel_q;
    logic [7:0]               data_q;
    logic [7:0]               data_d;
    logic [3:0]               cnt_q;
    logic                     ovf_q;
    logic                     start_q;
    logic [2:0]               port_q;
    logic [2:0]               dir_q;
    logic                     dataPrev_q;
    logic                     outMsb_q;

    assign accept = hsel & htrans[1] & hready;
    assign wrCtrl = wrPend_q & (addr_q == uwc_pkg::CTRL_ADDR);
    assign wrStat = wrPend_q & (addr_q == uwc_pkg::STAT_ADDR);
    assign wrData = wrPend_q & (addr_q == uwc_pkg::DATA_ADDR);
    assign wrPort = wrPend_q & (addr_q == uwc_pkg::PORT_ADDR);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q   <= uwc_pkg::REG_RESET;
        end else begin
            wrPend_q <= accept & hwrite;
            rdPend_q <= accept & ~hwrite;
            if (accept) begin
                addr_q <= haddr[uwc_pkg::ADDR_W-1:0];
            end
        end
    end

    // one wait state on reads so a write just before is visible
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (addr_q)
            uwc_pkg::CTRL_ADDR: rdMux[7:0] = {1'b0, ovfIe_q, wm_q, cs_q, 2'h0}; // R18
            uwc_pkg::STAT_ADDR: rdMux[7:0] = {start_q, ovf_q, 2'h0, cnt_q};
            uwc_pkg::DATA_ADDR: rdMux[7:0] = data_q;
            uwc_pkg::PORT_ADDR: rdMux[7:0] = {1'b0, dir_q, 1'b0, port_q};
            default:            rdMux      = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= ~(accept & ~hwrite);
            hresp     <= 1'b0;
            if (rdPend_q) begin
                hrdata <= rdMux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ovfIe_q  <= 1'b0;
            wm_q     <= uwc_pkg::WM_OFF;
            cs_q     <= uwc_pkg::CS_STROBE;
            clkSel_q <= 1'b0;
        end else if (wrCtrl) begin
            ovfIe_q  <= hwdata[uwc_pkg::CTRL_OVFIE]; // R1
            wm_q     <= uwc_pkg::uwc_wire_mode_e'(hwdata[uwc_pkg::CTRL_WM_HI:uwc_pkg::CTRL_WM_LO]);
            cs_q     <= hwdata[uwc_pkg::CTRL_CS_HI:uwc_pkg::CTRL_CS_LO];
            clkSel_q <= hwdata[uwc_pkg::CTRL_CLK];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock source selection
    logic swStrobe;
    logic togStrobe;
    logic timerClk;
    logic extShift;
    logic extLatch;
    logic shiftEn;
    logic cntEn;
    logic shiftIn;

    assign swStrobe  = wrCtrl & hwdata[uwc_pkg::CTRL_CLK]
                     & (hwdata[uwc_pkg::CTRL_CS_HI:uwc_pkg::CTRL_CS_LO] == uwc_pkg::CS_STROBE); // R14
    assign togStrobe = wrCtrl & hwdata[uwc_pkg::CTRL_TC];
    assign timerClk  = (cs_q == uwc_pkg::CS_TIMER) & timerMatch; // R15
    // sampling edge: rise for select 10, fall for select 11
    assign extShift  = cs_q[1] & (cs_q[0] ? pins.clkFall : pins.clkRise); // R15
    assign extLatch  = cs_q[1] & (cs_q[0] ? pins.clkRise : pins.clkFall); // R13
    assign shiftEn   = swStrobe | timerClk | extShift;
    assign cntEn     = swStrobe | timerClk
                     | (cs_q[1] & (clkSel_q ? togStrobe : (pins.clkRise | pins.clkFall))); // R15 R16
    // inputs feed the shifter whatever the wire mode
    assign shiftIn   = cs_q[1] ? pins.dataSync : dataPrev_q; // R3 R17

    ////////////////////////////////////////////////////////////////////////////
    // shift data register and output latch
    always_comb begin
        data_d = data_q;
        if (wrData) begin
            data_d = hwdata[7:0];
        end else if (shiftEn) begin
            data_d = {data_q[6:0], shiftIn};
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            data_q     <= uwc_pkg::REG_RESET;
            dataPrev_q <= 1'b0;
        end else begin
            data_q     <= data_d;
            dataPrev_q <= pins.dataSync; // R17
        end
    end

    // transparent for internal sources, opposite edge for external
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            outMsb_q <= 1'b0;
        end else if (~cs_q[1] | extLatch) begin
            outMsb_q <= data_d[7]; // R13 R19
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter and flags
    logic ovfSet;
    logic ovfClr;
    logic startSet;
    logic startClr;

    assign ovfSet   = cntEn & ~wrStat & (cnt_q == uwc_pkg::CNT_MAX); // R20
    assign ovfClr   = wrStat & hwdata[uwc_pkg::STAT_OVF];
    assign startSet = startDetected & wm_q[1];
    assign startClr = wrStat & hwdata[uwc_pkg::STAT_START];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= uwc_pkg::CNT_RESET;
        end else if (wrStat) begin
            cnt_q <= hwdata[uwc_pkg::CNT_HI:0];
        end else if (cntEn) begin
            cnt_q <= cnt_q + uwc_pkg::CNT_STEP;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ovf_q   <= 1'b0;
            start_q <= 1'b0;
        end else begin
            ovf_q   <= ovfSet | (ovf_q & ~ovfClr); // R20
            start_q <= startSet | (start_q & ~startClr); // R10
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ovfIrq <= 1'b0;
        end else begin
            ovfIrq <= ovf_q & ovfIe_q & globalIrqEn; // R1 R2
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port and direction bits
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            port_q <= uwc_pkg::PIN_RESET;
            dir_q  <= uwc_pkg::PIN_RESET;
        end else begin
            port_q <= (wrPort ? hwdata[2:0] : port_q) ^ (3'(togStrobe) << uwc_pkg::PIN_CK); // R6
            if (wrPort) begin
                dir_q <= hwdata[uwc_pkg::DIR_HI:uwc_pkg::DIR_LO];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers
    logic twoWire;
    logic sclHold;

    assign twoWire = wm_q[1];
    assign sclHold = start_q | ((wm_q == uwc_pkg::WM_TWO_HOLD) & ovf_q); // R10 R12

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sdaOut    <= 1'b0;
            sdaOe     <= 1'b0;
            sdaPullup <= 1'b0;
        end else if (twoWire) begin
            sdaOut    <= 1'b0; // R7
            sdaOe     <= dir_q[uwc_pkg::PIN_SDA] & (~outMsb_q | ~port_q[uwc_pkg::PIN_SDA]); // R8
            sdaPullup <= 1'b0; // R11
        end else begin
            sdaOut    <= port_q[uwc_pkg::PIN_SDA]; // R4 R6
            sdaOe     <= dir_q[uwc_pkg::PIN_SDA];
            sdaPullup <= ~dir_q[uwc_pkg::PIN_SDA] & port_q[uwc_pkg::PIN_SDA];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sclOut    <= 1'b0;
            sclOe     <= 1'b0;
            sclPullup <= 1'b0;
        end else if (twoWire) begin
            sclOut    <= 1'b0; // R7
            sclOe     <= dir_q[uwc_pkg::PIN_CK] & (~port_q[uwc_pkg::PIN_CK] | sclHold); // R9
            sclPullup <= 1'b0; // R11
        end else begin
            sclOut    <= port_q[uwc_pkg::PIN_CK]; // R4 R6
            sclOe     <= dir_q[uwc_pkg::PIN_CK];
            sclPullup <= ~dir_q[uwc_pkg::PIN_CK] & port_q[uwc_pkg::PIN_CK];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            doOut    <= 1'b0;
            doOe     <= 1'b0;
            doPullup <= 1'b0;
        end else begin
            doOut    <= (wm_q == uwc_pkg::WM_THREE) ? outMsb_q : port_q[uwc_pkg::PIN_DO]; // R5 R19
            doOe     <= dir_q[uwc_pkg::PIN_DO];
            doPullup <= ~dir_q[uwc_pkg::PIN_DO] & port_q[uwc_pkg::PIN_DO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence wrapSeq;
        cntEn && !wrStat && cnt_q == uwc_pkg::CNT_MAX;
    endsequence

    sequence holdSeq;
        wm_q == uwc_pkg::WM_TWO_HOLD && ovf_q && dir_q[uwc_pkg::PIN_CK];
    endsequence

    ovf_wrap_a: assert property (wrapSeq |=> ovf_q && cnt_q == 4'h0) // R20
        else $error("overflow flag not set on counter wrap");
    ovf_sticky_a: assert property (ovf_q && !ovfClr |=> ovf_q) // R20
        else $error("overflow flag lost without a clear");
    irq_fire_a: assert property (ovf_q && ovfIe_q && globalIrqEn |=> ovfIrq) // R2
        else $error("pending overflow did not raise the interrupt");
    strobe_shift_a: assert property (swStrobe && !wrData
        |=> data_q == {$past(data_q[6:0]), $past(dataPrev_q)}) // R17
        else $error("strobe shift used wrong data");
    timer_count_a: assert property (timerClk && !wrStat && !wrCtrl
        |=> cnt_q == 4'($past(cnt_q) + 4'h1)) // R15
        else $error("timer match did not step the counter");
    ovf_hold_a: assert property (holdSeq ##1 holdSeq |-> sclOe) // R12
        else $error("clock not held low after overflow");
    two_pull_a: assert property (twoWire |=> !sdaPullup && !sclPullup && !sdaOut) // R11
        else $error("pull-up or drive high in two-wire mode");
    sda_low_a: assert property (twoWire && dir_q[uwc_pkg::PIN_SDA] && !port_q[uwc_pkg::PIN_SDA] |=> sdaOe) // R8
        else $error("data line not pulled low");
    off_mode_a: assert property (wm_q == uwc_pkg::WM_OFF
        |=> doOut == $past(port_q[uwc_pkg::PIN_DO]) && sdaOe == $past(dir_q[uwc_pkg::PIN_SDA])) // R4
        else $error("pins not plain port pins in mode off");
    strobe_zero_a: assert property (rdPend_q && addr_q == uwc_pkg::CTRL_ADDR |=> hrdata[1:0] == 2'h0) // R18
        else $error("strobe bits read back nonzero");
    toggle_pin_a: assert property (togStrobe && !wrPort
        |=> port_q[uwc_pkg::PIN_CK] != $past(port_q[uwc_pkg::PIN_CK])) // R6
        else $error("toggle strobe did not flip clock port bit");
endmodule : uwc_wire_ctrl
`default_nettype wire

/* File: uwc_serial_peer.sv */
/*
 * serial peer: clocks 8-bit frames into the data and clock pins
 * assumes both lines resolved here, pull-ups on both
 */
`timescale 1ns/100ps
`default_nettype none
module uwc_serial_peer (
    input  wire logic       go,
    input  wire logic [7:0] txByte,
    input  wire logic       idleClk,
    input  wire logic       idleData,
    input  wire logic       holdData,
    input  wire logic       devOut,
    input  wire logic       sdaPull,
    input  wire logic       sclPull,
    output logic            sdaLine,
    output logic            sclLine,
    output logic [7:0]      rxByte,
    output logic            busy
);
    logic clkDrv = 1'b0;
    logic datDrv = 1'b0;
    logic junk   = 1'b0;
    initial rxByte = 8'h00;
    initial busy = 1'b0;
    // released data line toggles unless holdData keeps idleData
    always #5 junk = ~junk;
    always @(posedge go) begin
        #2.2 busy = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            clkDrv = 1'b0;
            datDrv = txByte[i];
            #24 clkDrv = 1'b1;
            #23 rxByte = {rxByte[6:0], devOut};
            #1;
        end
        clkDrv = 1'b0;
        busy = 1'b0;
    end
    // clock stands still between frames
    assign sclLine = (busy ? clkDrv : idleClk) & ~sclPull;
    assign sdaLine = (busy ? datDrv : (holdData ? idleData : junk)) & ~sdaPull;
endmodule : uwc_serial_peer
`default_nettype wire

/* File: uwc_wire_ctrl_tb_top.sv */
/*
 * self-checking bench of the wire and clock control block
 * assumes uwc_pkg, uwc_pin_if and design files compiled first
 */
`timescale 1ns/100ps
`default_nettype none
module uwc_wire_ctrl_tb_top;
    typedef struct { string w; logic [31:0] e; logic [31:0] m; } uwc_note_s;
    uwc_note_s   noteQ[$];
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, ovfIrq, sdaIn, sdaOut, sdaOe, sdaPullup;
    logic        doOut, doOe, doPullup, sclIn, sclOut, sclOe, sclPullup, busy;
    logic        timerMatch = 1'b0;
    logic        startDetected = 1'b0;
    logic        globalIrqEn = 1'b0;
    logic        go = 1'b0;
    logic        idleClk = 1'b0;
    logic        idleData = 1'b0;
    logic        holdData = 1'b1;
    logic [7:0]  txByte = 8'h00;
    logic [7:0]  rxByte;
    logic        rdPend = 1'b0;
    logic        pinReq = 1'b0;
    logic        busyQ = 1'b0;
    logic [7:0]  pinVec;
    logic [31:0] seed = 32'h47; // seeded at 71
    int          badCount = 0;
    int          nChecks = 0;
    int          cycles = 0;

    uwc_wire_ctrl uwc_wire_ctrl_inst (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .timerMatch(timerMatch), .startDetected(startDetected), .globalIrqEn(globalIrqEn),
        .ovfIrq(ovfIrq), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .sdaPullup(sdaPullup), .doOut(doOut),
        .doOe(doOe), .doPullup(doPullup), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sclPullup(sclPullup));
    uwc_serial_peer uwc_serial_peer_inst (.go(go), .txByte(txByte), .idleClk(idleClk), .idleData(idleData),
        .holdData(holdData), .devOut(doOut), .sdaPull(sdaOe & ~sdaOut), .sclPull(sclOe & ~sclOut),
        .sdaLine(sdaIn), .sclLine(sclIn), .rxByte(rxByte), .busy(busy));
    // pulled-low flags, data-out pin, pull-ups, interrupt
    assign pinVec = {sdaOe & ~sdaOut, sclOe & ~sclOut, doOut, doOe, doPullup, sdaPullup, sclPullup, ovfIrq};
    always #2.5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    function logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    function logic [7:0] ctl(input logic ie, input logic [1:0] wm, input logic [1:0] cs, input logic sb, input logic tc);
        return {1'b0, ie, wm, cs, sb, tc};
    endfunction : ctl
    task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", w, exp, seen);
        end
    endtask : check
    task automatic take(input logic [31:0] seen);
        uwc_note_s n;
        n = noteQ.pop_front();
        check(n.w, seen & n.m, n.e & n.m);
    endtask : take
    task automatic note(input string w, input logic [7:0] e, input logic [7:0] m);
        noteQ.push_back('{w, {24'h0, e}, {1'b1, 23'h0, m}});
    endtask : note
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
    endtask : bus
    task automatic rd(input string w, input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        note(w, e, m);
        bus(1'b0, a, 8'h00);
    endtask : rd
    task automatic pins(input string w, input logic [7:0] e, input logic [7:0] m);
        note(w, e, m);
        repeat (2) @(posedge ref_clk);
        pinReq <= 1'b1;
        @(posedge ref_clk);
        pinReq <= 1'b0;
    endtask : pins
    task automatic frame(input logic [7:0] t);
        txByte <= t;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        @(posedge ref_clk);
        while (busy !== 1'b0) @(posedge ref_clk);
    endtask : frame
    task automatic done(input string t);
        $display("test %s finished", t);
    endtask : done
    task automatic results();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        if (rdPend && hreadyout === 1'b1) take(hrdata | {hresp, 31'h0});
        if (pinReq) take({24'h0, pinVec});
        if (busyQ && !busy) take({24'h0, rxByte});
        busyQ <= busy;
        if (hreadyout === 1'b1) rdPend <= hsel & htrans[1] & ~hwrite;
        cycles++;
        if (cycles == 5000) begin
            badCount++;
            results();
        end
    end

    initial begin
        logic [7:0] d, t, x;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rd("ctrl", uwc_pkg::CTRL_ADDR, uwc_pkg::REG_RESET);
        rd("stat", uwc_pkg::STAT_ADDR, uwc_pkg::REG_RESET);
        rd("data", uwc_pkg::DATA_ADDR, uwc_pkg::REG_RESET);
        bus(1'b1, 8'h10, 8'hff);
        rd("hole", 8'h10, 8'h00);
        done("reset");
        x = rnd();
        bus(1'b1, uwc_pkg::DATA_ADDR, x);
        bus(1'b1, uwc_pkg::STAT_ADDR, 8'h0e);
        bus(1'b1, uwc_pkg::CTRL_ADDR, 8'h00);
        rd("no clock", uwc_pkg::DATA_ADDR, x);
        for (int b = 0; b < 2; b++) begin
            idleData <= b[0];
            repeat (4) @(posedge ref_clk);
            x = {x[6:0], b[0]};
            bus(1'b1, uwc_pkg::CTRL_ADDR, ctl(1'b0, 2'h0, 2'h0, 1'b1, 1'b0));
            rd("strobe shift", uwc_pkg::DATA_ADDR, x);
        end
        rd("strobe wrap", uwc_pkg::STAT_ADDR, 8'h40);
        rd("ctrl strobe", uwc_pkg::CTRL_ADDR, 8'h00);
        bus(1'b1, uwc_pkg::CTRL_ADDR, ctl(1'b0, 2'h0, 2'h1, 1'b0, 1'b0));
        timerMatch <= 1'b1;
        @(posedge ref_clk);
        timerMatch <= 1'b0;
        x = {x[6:0], 1'b1};
        rd("timer shift", uwc_pkg::DATA_ADDR, x);
        rd("timer count", uwc_pkg::STAT_ADDR, 8'h41);
        bus(1'b1, uwc_pkg::STAT_ADDR, 8'h01);
        rd("flag kept", uwc_pkg::STAT_ADDR, 8'h41);
        bus(1'b1, uwc_pkg::STAT_ADDR, 8'h41);
        rd("flag cleared", uwc_pkg::STAT_ADDR, 8'h01);
        done("internal clocks");
        bus(1'b1, uwc_pkg::STAT_ADDR, 8'h0f);
        bus(1'b1, uwc_pkg::CTRL_ADDR, ctl(1'b0, 2'h0, 2'h0, 1'b1, 1'b0));
        pins("irq masked", 8'h00, 8'h01);
        bus(1'b1, uwc_pkg::CTRL_ADDR, ctl(1'b1, 2'h0, 2'h0, 1'b0, 1'b0));
        pins("irq no global", 8'h00, 8'h01);
        globalIrqEn <= 1'b1;
        pins("irq pending", 8'h01, 8'h01);
        bus(1'b1, uwc_pkg::CTRL_ADDR, 8'h00);
        pins("irq off", 8'h00, 8'h01);
        done("interrupt");
        holdData <= 1'b0;
        bus(1'b1, uwc_pkg::PORT_ADDR, 8'h22);
        for (int i = 0; i < 4; i++) begin
            d = rnd();
            t = rnd();
            bus(1'b1, uwc_pkg::DATA_ADDR, d);
            bus(1'b1, uwc_pkg::STAT_ADDR, 8'h40);
            bus(1'b1, uwc_pkg::CTRL_ADDR, ctl(1'b0, {1'b0, i == 1}, {1'b1, i == 2}, i == 3, 1'b0));
            note("peer rx", (i == 1) ? {1'b0, d[6:0]} : 8'hff, (i == 1) ? 8'h7f : 8'hff);
            frame(t);
            rd("ext data", uwc_pkg::DATA_ADDR, t, (i == 2) ? 8'h00 : 8'hff);
            rd("ext count", uwc_pkg::STAT_ADDR, (i == 3) ? 8'h00 : 8'h40);
        end
        bus(1'b1, uwc_pkg::CTRL_ADDR, ctl(1'b0, 2'h0, 2'h2, 1'b1, 1'b1));
        rd("toggle count", uwc_pkg::STAT_ADDR, 8'h01);
        rd("toggle port", uwc_pkg::PORT_ADDR, 8'h26);
        done("external clocks");
        bus(1'b1, uwc_pkg::CTRL_ADDR, 8'h00);
        holdData <= 1'b1;
        idleData <= 1'b1;
        idleClk <= 1'b1;
        bus(1'b1, uwc_pkg::DATA_ADDR, 8'h00);
        pins("port do", 8'h30, 8'h30);
        bus(1'b1, uwc_pkg::CTRL_ADDR, ctl(1'b0, 2'h1, 2'h0, 1'b0, 1'b0));
        pins("three-wire do", 8'h10, 8'h30);
        bus(1'b1, uwc_pkg::PORT_ADDR, 8'h02);
        pins("do pull-up", 8'h08, 8'h08);
        bus(1'b1, uwc_pkg::CTRL_ADDR, ctl(1'b0, 2'h2, 2'h0, 1'b0, 1'b0));
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, uwc_pkg::DATA_ADDR, {k[1], 7'h00});
            bus(1'b1, uwc_pkg::PORT_ADDR, {7'h2a, k[0]});
            pins("sda drive", {~(k[1] & k[0]), 7'h00}, 8'hc6);
        end
        bus(1'b1, uwc_pkg::PORT_ADDR, 8'h51);
        pins("scl port low", 8'h40, 8'h40);
        bus(1'b1, uwc_pkg::PORT_ADDR, 8'h00);
        pins("drivers off", 8'h00, 8'hc0);
        bus(1'b1, uwc_pkg::PORT_ADDR, 8'h55);
        startDetected <= 1'b1;
        @(posedge ref_clk);
        startDetected <= 1'b0;
        pins("start hold", 8'h40, 8'h40);
        rd("start flag", uwc_pkg::STAT_ADDR, 8'h80, 8'h80);
        bus(1'b1, uwc_pkg::STAT_ADDR, 8'h80);
        pins("start release", 8'h00, 8'h40);
        for (int k = 2; k < 4; k++) begin
            bus(1'b1, uwc_pkg::STAT_ADDR, 8'h4f);
            bus(1'b1, uwc_pkg::CTRL_ADDR, ctl(1'b0, k[1:0], 2'h0, 1'b1, 1'b0));
            pins("overflow hold", {1'b0, k[0], 6'h00}, 8'h40);
            bus(1'b1, uwc_pkg::STAT_ADDR, 8'h40);
            pins("overflow release", 8'h00, 8'h40);
        end
        done("wire modes");
        results();
    end
endmodule : uwc_wire_ctrl_tb_top
`default_nettype wire
